// [logic/psc_pkg.sv]
package psc_pkg;
	// port layout selected by the compatibility strap
	typedef enum logic [1:0] {
		PSC_LAYOUT_X1_16   = 2'b00,
		PSC_LAYOUT_X4_2_X1 = 2'b01,
		PSC_LAYOUT_NATIVE  = 2'b10,
		PSC_LAYOUT_RSVD    = 2'b11
	} psc_layout_t;

	typedef enum logic [1:0] {
		PSC_RATE_1G25  = 2'b00,
		PSC_RATE_2G5   = 2'b01,
		PSC_RATE_3G125 = 2'b10,
		PSC_RATE_ILL   = 2'b11
	} psc_rate_t;

	localparam int          PSC_NUM_MAC      = 4;
	localparam int          PSC_NUM_X4_DUAL  = 2;
	localparam psc_rate_t   PSC_RATE_DEFAULT = PSC_RATE_3G125;
	localparam logic        PSC_REF_125      = 1'b1;

	// serial pll multipliers, line rate over reference
	localparam logic [4:0]  PSC_MULT_125_1G25  = 5'h0a;
	localparam logic [4:0]  PSC_MULT_125_2G5   = 5'h14;
	localparam logic [4:0]  PSC_MULT_125_3G125 = 5'h19;
	localparam logic [4:0]  PSC_MULT_156_1G25  = 5'h08;
	localparam logic [4:0]  PSC_MULT_156_2G5   = 5'h10;
	localparam logic [4:0]  PSC_MULT_156_3G125 = 5'h14;

	// register map, byte addresses
	localparam logic [7:0]  PSC_OFS_MAC_CFG0 = 8'h00;
	localparam logic [7:0]  PSC_OFS_STATUS   = 8'h10;
	localparam int          PSC_CFG_W        = 5;
	// mac cfg field positions
	localparam int          PSC_F_RATE     = 0;
	localparam int          PSC_F_RX_SWAP  = 2;
	localparam int          PSC_F_TX_SWAP  = 3;
	localparam int          PSC_F_X1_MODE  = 4;
	// status field positions
	localparam int          PSC_S_COMP     = 0;
	localparam int          PSC_S_RATE     = 2;
	localparam int          PSC_S_REF      = 4;
	localparam int          PSC_S_RX       = 5;
	localparam int          PSC_S_TX       = 6;
	localparam int          PSC_S_MODE     = 7;
	localparam int          PSC_S_COMP_BAD = 11;
	localparam int          PSC_S_RATE_BAD = 12;
	localparam int          PSC_S_CONFLICT = 13;
	localparam int          PSC_S_SAMPLED  = 17;

	localparam logic [1:0]  PSC_RESP_OKAY   = 2'b00;
	localparam logic [1:0]  PSC_RESP_SLVERR = 2'b10;
	localparam logic [31:0] PSC_RDATA_RST   = 32'h0000_0000;
endpackage

// [logic/psc_mac_if.sv]
`timescale 1ns/1ps
interface psc_mac_if;
	logic [1:0] line_rate;
	logic       rx_swap;
	logic       tx_swap;
	logic       x1_field;
	logic [1:0] layout;
	logic       ref125;
	logic       x1_eff;
	logic       rx_rev;
	logic       tx_rev;
	logic [4:0] pll_mult;
	logic       conflict;

	modport cfg (output line_rate, rx_swap, tx_swap, x1_field, layout, ref125,
		input x1_eff, rx_rev, tx_rev, pll_mult, conflict);
	modport dec (input line_rate, rx_swap, tx_swap, x1_field, layout, ref125,
		output x1_eff, rx_rev, tx_rev, pll_mult, conflict);
endinterface

// [logic/psc_mac_decode.sv]
`timescale 1ns/1ps
module psc_mac_decode #(
	parameter int MAC_IDX = 0
) (
	psc_mac_if.dec m
);
	always_comb begin
		unique case (m.layout)
			psc_pkg::PSC_LAYOUT_X1_16:   m.x1_eff = 1'b1;
			psc_pkg::PSC_LAYOUT_X4_2_X1: m.x1_eff = (MAC_IDX >= psc_pkg::PSC_NUM_X4_DUAL) |
				m.x1_field;
			default:                     m.x1_eff = m.x1_field;
		endcase
	end

	// single-lane ports never reorder lanes
	assign m.rx_rev   = m.rx_swap & ~m.x1_eff;
	assign m.tx_rev   = m.tx_swap & ~m.x1_eff;
	// swapped lanes in single-lane mode cannot reach a 1x partner
	assign m.conflict = (m.rx_swap | m.tx_swap) & m.x1_eff;

	always_comb begin
		unique case ({m.ref125, m.line_rate})
			{psc_pkg::PSC_REF_125, psc_pkg::PSC_RATE_1G25}: m.pll_mult = psc_pkg::PSC_MULT_125_1G25;
			{psc_pkg::PSC_REF_125, psc_pkg::PSC_RATE_2G5}:  m.pll_mult = psc_pkg::PSC_MULT_125_2G5;
			{~psc_pkg::PSC_REF_125, psc_pkg::PSC_RATE_1G25}:
				m.pll_mult = psc_pkg::PSC_MULT_156_1G25;
			{~psc_pkg::PSC_REF_125, psc_pkg::PSC_RATE_2G5}:
				m.pll_mult = psc_pkg::PSC_MULT_156_2G5;
			default: m.pll_mult = m.ref125 ? psc_pkg::PSC_MULT_125_3G125 :
				psc_pkg::PSC_MULT_156_3G125;
		endcase
	end
endmodule // psc_mac_decode

// [logic/psc_strap_config.sv]
// Overview of operation
// - compatibility strap 00 sixteen x1, 01 two x4 plus eight x1, 10 native
// - line-rate strap 00 1.25G, 01 2.5G, 10 3.125G default; 11 illegal
// - captured line-rate strap loads the per-MAC line-rate register field
// - refclk select strap 1 means 125 MHz, 0 means 156.25 MHz; picks pll
// - rx and tx lane-order straps: 0 natural order, 1 reversed order
// - register lane-swap fields override the lane-order straps
// - lane-order straps ignored for ports in single-lane mode
// - a lane-swapped port must stay four-lane; swap in x1 is flagged
// - line-rate and refclk strap pins drive out only in test mode
// - per-Mac_lane_mode_field strap 0 four-lane, 1 single-lane; register field overrides
// - hard reset is asynchronous active low and resets strap capture
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module psc_strap_config (
	input  wire logic        SYS_CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        HARD_RST_N_IN,
	input  wire logic        TEST_MODE_IN,
	input  wire logic [1:0]  COMPAT_MODE_STRAP_IN,
	input  wire logic [1:0]  LINE_RATE_STRAP_IN,
	output logic [1:0]       LINE_RATE_STRAP_OUT,
	output logic [1:0]       LINE_RATE_STRAP_OE_N_OUT,
	input  wire logic        REFCLK_SELECT_STRAP_IN,
	output logic             REFCLK_SELECT_STRAP_OUT,
	output logic             REFCLK_SELECT_STRAP_OE_N_OUT,
	input  wire logic        RX_LANE_ORDER_STRAP_IN,
	input  wire logic        TX_LANE_ORDER_STRAP_IN,
	input  wire logic [3:0]  MAC_LANE_MODE_STRAP_IN,
	output logic [1:0]       PORT_LAYOUT_OUT,
	output logic             REFCLK_125_OUT,
	output logic [7:0]       LINE_RATE_OUT,
	output logic [3:0]       MAC_X1_MODE_OUT,
	output logic [3:0]       RX_LANE_REV_OUT,
	output logic [3:0]       TX_LANE_REV_OUT,
	output logic [19:0]      PLL_MULT_OUT,
	output logic             POWERUP_SAMPLED_OUT,
	input  wire logic [7:0]  AXI_AWADDR_IN,
	input  wire logic        AXI_AWVALID_IN,
	output logic             AXI_AWREADY_OUT,
	input  wire logic [31:0] AXI_WDATA_IN,
	input  wire logic [3:0]  AXI_WSTRB_IN,
	input  wire logic        AXI_WVALID_IN,
	output logic             AXI_WREADY_OUT,
	output logic [1:0]       AXI_BRESP_OUT,
	output logic             AXI_BVALID_OUT,
	input  wire logic        AXI_BREADY_IN,
	input  wire logic [7:0]  AXI_ARADDR_IN,
	input  wire logic        AXI_ARVALID_IN,
	output logic             AXI_ARREADY_OUT,
	output logic [31:0]      AXI_RDATA_OUT,
	output logic [1:0]       AXI_RRESP_OUT,
	output logic             AXI_RVALID_OUT,
	input  wire logic        AXI_RREADY_IN
);
	localparam int SW = 11;
	localparam int NM = psc_pkg::PSC_NUM_MAC;

	// hard reset: asserts at once, releases on the clock
	logic          hrst_meta_r;
	logic          hrst_sync_r;
	always_ff @(posedge SYS_CLK_IN or negedge HARD_RST_N_IN) begin
		if (!HARD_RST_N_IN) begin
			hrst_meta_r <= 1'b1;
			hrst_sync_r <= 1'b1;
		end else begin
			hrst_meta_r <= 1'b0;
			hrst_sync_r <= hrst_meta_r;
		end
	end
	logic          rst_any;
	assign rst_any = RST_IN | hrst_sync_r;

	// strap pins and test mode are asynchronous to the clock
	logic [SW-1:0] strap_meta_r;
	logic [SW-1:0] strap_sync_r;
	logic          test_meta_r;
	logic          test_sync_r;
	always_ff @(posedge SYS_CLK_IN) begin
		strap_meta_r <= {MAC_LANE_MODE_STRAP_IN, TX_LANE_ORDER_STRAP_IN, RX_LANE_ORDER_STRAP_IN,
			REFCLK_SELECT_STRAP_IN, LINE_RATE_STRAP_IN, COMPAT_MODE_STRAP_IN};
		strap_sync_r <= strap_meta_r;
		test_meta_r  <= TEST_MODE_IN;
		test_sync_r  <= test_meta_r;
	end

	// capture tracks the pins for the whole reset, then freezes
	logic [SW-1:0] cap_r;
	logic [SW-1:0] cap_nxt;
	logic          sampled_r;
	logic          sampled_nxt;
	always_comb begin
		cap_nxt     = rst_any ? strap_sync_r : cap_r;
		sampled_nxt = ~rst_any;
	end
	always_ff @(posedge SYS_CLK_IN) begin
		cap_r     <= cap_nxt;
		sampled_r <= sampled_nxt;
	end
	logic [1:0]    cap_comp;
	logic [1:0]    cap_rate;
	logic          cap_ref;
	assign cap_comp = cap_r[1:0];
	assign cap_rate = cap_r[3:2];
	assign cap_ref  = cap_r[4];

	// axi4-lite slave, one write and one read at a time
	logic          aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [7:0]    aw_addr_r, aw_addr_nxt;
	logic [31:0]   w_data_r, w_data_nxt;
	logic          w_strb0_r, w_strb0_nxt;
	logic          awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0]    bresp_nxt, rresp_nxt;
	logic [31:0]   rdata_nxt;
	logic          do_wr;
	logic [7:0]    wr_addr;
	logic [31:0]   wr_data;
	logic          wr_strb0;
	logic [31:0]   status;
	localparam int PSC_CFG_W_L = psc_pkg::PSC_CFG_W;
	logic [PSC_CFG_W_L-1:0] mac_cfg_r [NM];
	logic [PSC_CFG_W_L-1:0] mac_cfg_nxt [NM];
	logic [NM-1:0] conflict_v;

	always_comb begin
		aw_got_nxt  = aw_got_r | (AXI_AWVALID_IN & AXI_AWREADY_OUT);
		w_got_nxt   = w_got_r | (AXI_WVALID_IN & AXI_WREADY_OUT);
		aw_addr_nxt = (AXI_AWVALID_IN & AXI_AWREADY_OUT) ? AXI_AWADDR_IN : aw_addr_r;
		w_data_nxt  = (AXI_WVALID_IN & AXI_WREADY_OUT) ? AXI_WDATA_IN : w_data_r;
		w_strb0_nxt = (AXI_WVALID_IN & AXI_WREADY_OUT) ? AXI_WSTRB_IN[0] : w_strb0_r;
		wr_addr     = aw_addr_nxt;
		wr_data     = w_data_nxt;
		wr_strb0    = w_strb0_nxt;
		do_wr       = aw_got_nxt & w_got_nxt & ~AXI_BVALID_OUT;
		bvalid_nxt  = AXI_BVALID_OUT & ~AXI_BREADY_IN;
		bresp_nxt   = AXI_BRESP_OUT;
		if (do_wr) begin
			aw_got_nxt = 1'b0;
			w_got_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = (wr_addr[7:4] == 4'h0 && wr_addr[1:0] == 2'b00) ?
				psc_pkg::PSC_RESP_OKAY : psc_pkg::PSC_RESP_SLVERR;
		end
		awready_nxt = ~aw_got_nxt & ~bvalid_nxt;
		wready_nxt  = ~w_got_nxt & ~bvalid_nxt;
		rvalid_nxt  = AXI_RVALID_OUT & ~AXI_RREADY_IN;
		rdata_nxt   = AXI_RDATA_OUT;
		rresp_nxt   = AXI_RRESP_OUT;
		if (AXI_ARVALID_IN & AXI_ARREADY_OUT) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = psc_pkg::PSC_RESP_OKAY;
			rdata_nxt  = psc_pkg::PSC_RDATA_RST;
			if (AXI_ARADDR_IN[7:4] == 4'h0 && AXI_ARADDR_IN[1:0] == 2'b00)
				rdata_nxt[PSC_CFG_W_L-1:0] = mac_cfg_r[AXI_ARADDR_IN[3:2]];
			else if (AXI_ARADDR_IN == psc_pkg::PSC_OFS_STATUS)
				rdata_nxt = status;
			else
				rresp_nxt = psc_pkg::PSC_RESP_SLVERR;
		end
		arready_nxt = ~rvalid_nxt;
		if (rst_any) begin
			aw_got_nxt  = 1'b0;
			w_got_nxt   = 1'b0;
			awready_nxt = 1'b0;
			wready_nxt  = 1'b0;
			bvalid_nxt  = 1'b0;
			bresp_nxt   = psc_pkg::PSC_RESP_OKAY;
			arready_nxt = 1'b0;
			rvalid_nxt  = 1'b0;
			rresp_nxt   = psc_pkg::PSC_RESP_OKAY;
			rdata_nxt   = psc_pkg::PSC_RDATA_RST;
		end
	end
	always_ff @(posedge SYS_CLK_IN) begin
		aw_got_r        <= aw_got_nxt;
		w_got_r         <= w_got_nxt;
		aw_addr_r       <= aw_addr_nxt;
		w_data_r        <= w_data_nxt;
		w_strb0_r       <= w_strb0_nxt;
		AXI_AWREADY_OUT <= awready_nxt;
		AXI_WREADY_OUT  <= wready_nxt;
		AXI_BVALID_OUT  <= bvalid_nxt;
		AXI_BRESP_OUT   <= bresp_nxt;
		AXI_ARREADY_OUT <= arready_nxt;
		AXI_RVALID_OUT  <= rvalid_nxt;
		AXI_RRESP_OUT   <= rresp_nxt;
		AXI_RDATA_OUT   <= rdata_nxt;
	end

	// per-MAC line-rate, lane-swap and lane-mode registers, seeded from the straps
	always_comb begin
		for (int i = 0; i < NM; i++) begin
			mac_cfg_nxt[i] = mac_cfg_r[i];
			if (rst_any)
				mac_cfg_nxt[i] = {strap_sync_r[7 + i], strap_sync_r[6], strap_sync_r[5],
					strap_sync_r[3:2]};
			else if (do_wr && wr_strb0 && wr_addr[7:4] == 4'h0 && wr_addr[1:0] == 2'b00 &&
				wr_addr[3:2] == 2'(i))
				mac_cfg_nxt[i] = wr_data[PSC_CFG_W_L-1:0];
		end
	end
	always_ff @(posedge SYS_CLK_IN) begin
		mac_cfg_r <= mac_cfg_nxt;
	end

	// per-MAC decode
	psc_mac_if mif [NM] ();
	logic [1:0]  lay_nxt;
	logic [7:0]  rate_nxt;
	logic [3:0]  x1_nxt, rxr_nxt, txr_nxt;
	logic [19:0] mult_nxt;
	for (genvar g = 0; g < NM; g++) begin : g_mac
		assign mif[g].line_rate = mac_cfg_r[g][psc_pkg::PSC_F_RATE +: 2];
		assign mif[g].rx_swap   = mac_cfg_r[g][psc_pkg::PSC_F_RX_SWAP];
		assign mif[g].tx_swap   = mac_cfg_r[g][psc_pkg::PSC_F_TX_SWAP];
		assign mif[g].x1_field  = mac_cfg_r[g][psc_pkg::PSC_F_X1_MODE];
		assign mif[g].layout    = lay_nxt;
		assign mif[g].ref125    = cap_ref;
		assign x1_nxt[g]        = mif[g].x1_eff;
		assign rxr_nxt[g]       = mif[g].rx_rev;
		assign txr_nxt[g]       = mif[g].tx_rev;
		assign conflict_v[g]    = mif[g].conflict;
		assign rate_nxt[2*g +: 2]  = mif[g].line_rate;
		assign mult_nxt[5*g +: 5]  = mif[g].pll_mult;
		psc_mac_decode #(.MAC_IDX(g)) u_dec (
			.m (mif[g].dec)
		);
	end
	// a reserved layout falls back to native
	assign lay_nxt = (cap_comp == psc_pkg::PSC_LAYOUT_RSVD) ? psc_pkg::PSC_LAYOUT_NATIVE :
		cap_comp;

	assign status = {14'h0000, sampled_r, conflict_v, (cap_rate == psc_pkg::PSC_RATE_ILL),
		(cap_comp == psc_pkg::PSC_LAYOUT_RSVD), cap_r[SW-1:2], cap_comp};

	always_ff @(posedge SYS_CLK_IN) begin
		PORT_LAYOUT_OUT     <= lay_nxt;
		REFCLK_125_OUT      <= cap_ref;
		LINE_RATE_OUT       <= rate_nxt;
		MAC_X1_MODE_OUT     <= x1_nxt;
		RX_LANE_REV_OUT     <= rxr_nxt;
		TX_LANE_REV_OUT     <= txr_nxt;
		PLL_MULT_OUT        <= mult_nxt;
		POWERUP_SAMPLED_OUT <= sampled_r;
		// drive back the held straps only for test
		LINE_RATE_STRAP_OUT          <= cap_rate;
		LINE_RATE_STRAP_OE_N_OUT     <= {2{~(test_sync_r & ~rst_any)}};
		REFCLK_SELECT_STRAP_OUT      <= cap_ref;
		REFCLK_SELECT_STRAP_OE_N_OUT <= ~(test_sync_r & ~rst_any);
	end

	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (rst_any);

	AST_LAYOUT: assert property (sampled_r |=> PORT_LAYOUT_OUT != psc_pkg::PSC_LAYOUT_RSVD &&
		(PORT_LAYOUT_OUT == $past(cap_comp) || $past(cap_comp) == psc_pkg::PSC_LAYOUT_RSVD))
		else $error("layout output does not follow strap");
	AST_RATE_SEED: assert property ($rose(sampled_r) |-> mac_cfg_r[1][1:0] == cap_rate)
		else $error("line rate field not seeded from strap");
	AST_RATE_OUT: assert property (sampled_r ##1 sampled_r |-> LINE_RATE_OUT[3:2] ==
		$past(mac_cfg_r[1][1:0]))
		else $error("line rate output wrong");
	AST_REFCLK: assert property (sampled_r |=> REFCLK_125_OUT == cap_ref &&
		(cap_ref || PLL_MULT_OUT[4:0] != psc_pkg::PSC_MULT_125_3G125))
		else $error("refclk select wrong");
	AST_X1_NO_SWAP: assert property ((MAC_X1_MODE_OUT & (RX_LANE_REV_OUT | TX_LANE_REV_OUT))
		== 4'h0)
		else $error("lane reversal in single-lane mode");
	AST_SWAP_OVR: assert property (sampled_r |=> RX_LANE_REV_OUT[0] ==
		$past(mac_cfg_r[0][psc_pkg::PSC_F_RX_SWAP] & ~x1_nxt[0]))
		else $error("lane swap field not applied");
	AST_CONFLICT: assert property (x1_nxt[2] && mac_cfg_r[2][psc_pkg::PSC_F_TX_SWAP] |->
		status[psc_pkg::PSC_S_CONFLICT + 2])
		else $error("swap conflict not flagged");
	AST_PIN_DIR: assert property (!test_sync_r ##1 !test_sync_r |->
		LINE_RATE_STRAP_OE_N_OUT == 2'b11 && REFCLK_SELECT_STRAP_OE_N_OUT)
		else $error("strap pin driven outside test mode");
	AST_MODE_FIELD: assert property (lay_nxt == psc_pkg::PSC_LAYOUT_NATIVE |=>
		MAC_X1_MODE_OUT[3] == $past(mac_cfg_r[3][psc_pkg::PSC_F_X1_MODE]))
		else $error("mode field not applied");
	AST_HARD_RST: assert property (disable iff (1'b0) hrst_sync_r |=> !sampled_r &&
		!AXI_AWREADY_OUT && !AXI_ARREADY_OUT)
		else $error("hard reset ignored");
	AST_HOLD: assert property (sampled_r |=> $stable(cap_r))
		else $error("strap capture changed after reset");
endmodule // psc_strap_config

// [test/psc_strap_model.sv]
`timescale 1ns/1ps
module psc_strap_model (
	input  wire logic [1:0] rate_lvl_in,
	input  wire logic       ref_lvl_in,
	input  wire logic [1:0] rate_pin_in,
	input  wire logic [1:0] rate_oe_n_in,
	input  wire logic       ref_pin_in,
	input  wire logic       ref_oe_n_in,
	output logic [1:0]      rate_wire_out,
	output logic            ref_wire_out
);
	// resistor level wins unless the chip drives the pin
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			rate_wire_out[i] = rate_oe_n_in[i] ? rate_lvl_in[i] : rate_pin_in[i];
		end
		ref_wire_out = ref_oe_n_in ? ref_lvl_in : ref_pin_in;
	end
endmodule // psc_strap_model

// [test/psc_strap_config_tb_top.sv]
`timescale 1ns/1ps
module psc_strap_config_tb_top;
	logic        clk = 1'h0, rst = 1'h1, hrst_n = 1'h1, tmode = 1'h0;
	logic [1:0]  compat = 2'h2, rate_lvl = 2'h2;
	logic        ref_lvl = 1'h0, rx_s = 1'h0, tx_s = 1'h0;
	logic [3:0]  mode_s = 4'h0;
	logic [1:0]  rate_w, rate_o, rate_oe_n, layout, bresp, rresp;
	logic        ref_w, ref_o, ref_oe_n, ref125, smp, awr, wr, bv, arr, rv;
	logic [7:0]  lrate, awaddr = 8'h00, araddr = 8'h00;
	logic [3:0]  x1, rxr, txr;
	logic [19:0] pll;
	logic [31:0] wdata = 32'h0000_0000, rdata, d;
	logic        awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
	logic [1:0]  r;
	int          errors = 0, comparisons = 0;

	always #20 clk = ~clk;

	psc_strap_model u_psc_strap_model (.rate_lvl_in(rate_lvl), .ref_lvl_in(ref_lvl),
		.rate_pin_in(rate_o), .rate_oe_n_in(rate_oe_n), .ref_pin_in(ref_o),
		.ref_oe_n_in(ref_oe_n), .rate_wire_out(rate_w), .ref_wire_out(ref_w));

	psc_strap_config u_psc_strap_config (.SYS_CLK_IN(clk), .RST_IN(rst),
		.HARD_RST_N_IN(hrst_n), .TEST_MODE_IN(tmode), .COMPAT_MODE_STRAP_IN(compat),
		.LINE_RATE_STRAP_IN(rate_w), .LINE_RATE_STRAP_OUT(rate_o),
		.LINE_RATE_STRAP_OE_N_OUT(rate_oe_n), .REFCLK_SELECT_STRAP_IN(ref_w),
		.REFCLK_SELECT_STRAP_OUT(ref_o), .REFCLK_SELECT_STRAP_OE_N_OUT(ref_oe_n),
		.RX_LANE_ORDER_STRAP_IN(rx_s), .TX_LANE_ORDER_STRAP_IN(tx_s),
		.MAC_LANE_MODE_STRAP_IN(mode_s), .PORT_LAYOUT_OUT(layout), .REFCLK_125_OUT(ref125),
		.LINE_RATE_OUT(lrate), .MAC_X1_MODE_OUT(x1), .RX_LANE_REV_OUT(rxr),
		.TX_LANE_REV_OUT(txr), .PLL_MULT_OUT(pll), .POWERUP_SAMPLED_OUT(smp),
		.AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr),
		.AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hf), .AXI_WVALID_IN(wv),
		.AXI_WREADY_OUT(wr), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bv),
		.AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arv),
		.AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
		.AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rready));

	task automatic tally_and_finish;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic hang(input string what);
		errors++;
		$display("[ERR] %s expected answer seen none", what);
		tally_and_finish();
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
		logic aw_done, w_done;
		aw_done = 1'h0;
		w_done = 1'h0;
		awaddr <= a;
		wdata <= dv;
		awv <= 1'h1;
		wv <= 1'h1;
		bready <= 1'h1;
		for (int n = 0; !(aw_done && w_done); n++) begin
			if (n == 40) hang("awready");
			@(posedge clk);
			if (awr === 1'h1 && !aw_done) begin
				aw_done = 1'h1;
				awv <= 1'h0;
			end
			if (wr === 1'h1 && !w_done) begin
				w_done = 1'h1;
				wv <= 1'h0;
			end
		end
		for (int n = 0; bv !== 1'h1; n++) begin
			if (n == 40) hang("bvalid");
			@(posedge clk);
		end
		rs = bresp;
		bready <= 1'h0;
		@(posedge clk);
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
		araddr <= a;
		arv <= 1'h1;
		rready <= 1'h1;
		// arready is judged only at an edge where arvalid already stands
		@(posedge clk);
		for (int n = 0; arr !== 1'h1; n++) begin
			if (n == 40) hang("arready");
			@(posedge clk);
		end
		arv <= 1'h0;
		for (int n = 0; rv !== 1'h1; n++) begin
			if (n == 40) hang("rvalid");
			@(posedge clk);
		end
		dv = rdata;
		rs = rresp;
		rready <= 1'h0;
		@(posedge clk);
	endtask

	function automatic logic [4:0] mult(input logic f, input logic [1:0] rt);
		case ({f, rt})
			3'h4: mult = 5'h0a;
			3'h5: mult = 5'h14;
			3'h6, 3'h7: mult = 5'h19;
			3'h0: mult = 5'h08;
			3'h1: mult = 5'h10;
			default: mult = 5'h14;
		endcase
	endfunction

	task automatic check_straps(input logic [1:0] c, rt, input logic f, rx, tx, input logic [3:0] m);
		logic [3:0] xe;
		xe = (c == 2'h0) ? 4'hf : ((c == 2'h1) ? (m | 4'hc) : m);
		check("layout", 32'(c), 32'(layout));
		check("line_rate", 32'({4{rt}}), 32'(lrate));
		check("refclk", 32'(f), 32'(ref125));
		check("pll", 32'({4{mult(f, rt)}}), 32'(pll));
		check("x1_mode", 32'(xe), 32'(x1));
		check("rx_rev", 32'({4{rx}} & ~xe), 32'(rxr));
		check("tx_rev", 32'({4{tx}} & ~xe), 32'(txr));
		check("sampled", 32'h0000_0001, 32'(smp));
	endtask

	task automatic strap_reset(input logic [1:0] c, rt, input logic f, rx, tx, input logic [3:0] m);
		rst <= 1'h1;
		compat <= c;
		rate_lvl <= rt;
		ref_lvl <= f;
		rx_s <= rx;
		tx_s <= tx;
		mode_s <= m;
		repeat (5) @(posedge clk);
		check("sampled_rst", 32'h0000_0000, 32'(smp));
		rst <= 1'h0;
		repeat (4) @(posedge clk);
		// later pin changes must not reach the captured set
		ref_lvl <= ~f;
		rx_s <= ~rx;
		tx_s <= ~tx;
		mode_s <= ~m;
		repeat (3) @(posedge clk);
		check_straps(c, rt, f, rx, tx, m);
	endtask

	task automatic reg_override;
		axi_read(8'h00, d, r);
		check("cfg0", 32'h0000_000e, d);
		axi_write(8'h04, 32'h0000_0001, r);
		check("wr_resp", 32'h0000_0000, 32'(r));
		repeat (3) @(posedge clk);
		check("rx_rev_ovr", 32'h0000_000d, 32'(rxr));
		check("rate_ovr", 32'h0000_00a6, 32'(lrate));
		check("pll1", 32'h0000_0010, 32'(pll[9:5]));
		axi_write(8'h08, 32'h0000_001e, r);
		repeat (3) @(posedge clk);
		check("rx_rev_x1", 32'h0000_0009, 32'(rxr));
		check("tx_rev_x1", 32'h0000_0009, 32'(txr));
		axi_read(8'h10, d, r);
		check("conflict", 32'h0000_0001, 32'(d[15]));
		check("status", 32'h0000_000a, 32'(d[4:0]));
		axi_read(8'h20, d, r);
		check("bad_resp", 32'h0000_0002, 32'(r));
		check("bad_data", 32'h0000_0000, d);
	endtask

	task automatic test_mode_drive(input logic [1:0] rt, input logic f);
		tmode <= 1'h1;
		repeat (5) @(posedge clk);
		check("rate_oe_n", 32'h0000_0000, 32'(rate_oe_n));
		check("ref_oe_n", 32'h0000_0000, 32'(ref_oe_n));
		check("rate_drv", 32'(rt), 32'(rate_o));
		check("ref_drv", 32'(f), 32'(ref_o));
		tmode <= 1'h0;
		repeat (5) @(posedge clk);
		check("rate_oe_off", 32'h0000_0003, 32'(rate_oe_n));
		check("ref_oe_off", 32'h0000_0001, 32'(ref_oe_n));
	endtask

	task automatic hard_reset;
		hrst_n <= 1'h0;
		rate_lvl <= 2'h0;
		ref_lvl <= 1'h1;
		rx_s <= 1'h0;
		tx_s <= 1'h0;
		mode_s <= 4'hf;
		repeat (5) @(posedge clk);
		check("sampled_hrst", 32'h0000_0000, 32'(smp));
		hrst_n <= 1'h1;
		repeat (6) @(posedge clk);
		check_straps(2'h2, 2'h0, 1'h1, 1'h0, 1'h0, 4'hf);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		repeat (3) @(posedge clk);
		strap_reset(2'h0, 2'h0, 1'h1, 1'h1, 1'h1, 4'h0);
		strap_reset(2'h1, 2'h1, 1'h0, 1'h1, 1'h0, 4'h2);
		strap_reset(2'h2, 2'h2, 1'h1, 1'h0, 1'h1, 4'h5);
		strap_reset(2'h2, 2'h2, 1'h0, 1'h1, 1'h1, 4'h0);
		reg_override();
		test_mode_drive(2'h2, 1'h0);
		hard_reset();
		test_mode_drive(2'h0, 1'h1);
		tally_and_finish();
	end
endmodule // psc_strap_config_tb_top
